// [rtl/fdr_pkg.sv]
// constants shared by the flash data read command handler
package fdr_pkg;
    // report format
    localparam int REPORT_BYTES = 64;
    localparam int WORD_BYTES = 4;
    localparam int NUM_STORED_SETS = 5;
    localparam int FLASH_BYTES = NUM_STORED_SETS * REPORT_BYTES;
    localparam logic [7:0] CMD_READ_FLASH = 8'hb0;
    localparam logic [7:0] SUB_CHIP_SETTINGS = 8'h00;
    localparam logic [7:0] SUB_PIN_SETTINGS = 8'h01;
    localparam logic [7:0] SUB_MFR_STRING = 8'h02;
    localparam logic [7:0] SUB_PRODUCT_STRING = 8'h03;
    localparam logic [7:0] SUB_USER_SERIAL = 8'h04;
    localparam logic [7:0] SUB_FACTORY_SERIAL = 8'h05;
    localparam logic [7:0] STS_OK = 8'h00;
    localparam logic [7:0] STS_UNSUPPORTED = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [5:0] REQ_CMD_IDX = 6'h00;
    localparam logic [5:0] REQ_SUB_IDX = 6'h01;
    localparam logic [5:0] RSP_CMD_IDX = 6'h00;
    localparam logic [5:0] RSP_STS_IDX = 6'h01;
    localparam logic [5:0] RSP_LEN_IDX = 6'h02;
    localparam logic [5:0] RSP_DATA_IDX = 6'h03;
    localparam logic [5:0] RSP_LAST_IDX = 6'h3f;
    localparam logic [5:0] CS_FLAGS_IDX = 6'h04;
    // chip settings flag byte fields
    localparam int CS_SERIAL_EN_BIT = 7;
    localparam int CS_RX_IDLE_BIT = 6;
    localparam int CS_TX_IDLE_BIT = 5;
    localparam int CS_I2C_IDLE_BIT = 4;
    localparam int CS_SUSPEND_IDLE_BIT = 3;
    localparam int CS_CONFIG_IDLE_BIT = 2;
    localparam int CS_LOCK_BIT = 1;
    localparam int CS_SEC_LSB = 0;
    localparam int CS_SEC_W = 2;
    // word address map
    localparam int ADDR_W = 8;
    localparam logic [7:0] A_REQ_BASE = 8'h00;
    localparam logic [7:0] A_REQ_END = 8'h0f;
    localparam logic [7:0] A_RSP_BASE = 8'h10;
    localparam logic [7:0] A_RSP_END = 8'h1f;
    localparam logic [7:0] A_CTRL = 8'h20;
    localparam logic [7:0] A_STATUS = 8'h21;
    localparam logic [7:0] A_LEN_BASE = 8'h30;
    localparam logic [7:0] A_LEN_END = 8'h34;
    localparam logic [7:0] A_FLASH_BASE = 8'h40;
    localparam logic [7:0] A_FLASH_END = 8'h8f;
    localparam int CTRL_GO_BIT = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_SERIAL_EN_BIT = 2;
    localparam int ST_LOCKED_BIT = 3;
    localparam int ST_SEC_LSB = 4;
    // reset values
    localparam logic [7:0] LEN_RST = 8'h00;
    localparam logic [7:0] FLASH_RST = 8'h00;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    typedef enum logic [1:0] {FDR_IDLE, FDR_HEAD, FDR_COPY} fdr_state_t;
endpackage

// [rtl/fdr_indicators.sv]
// activity and status indicator pins driven from the idle levels
`timescale 1ns/1ps
`default_nettype none
module fdr_indicators (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // idle levels and activity
    input wire logic [7:0] flags,
    input wire logic rx_active,
    input wire logic tx_active,
    input wire logic i2c_active,
    input wire logic i2c_ind_en,
    input wire logic suspended,
    input wire logic suspend_ind_en,
    input wire logic usb_configured,
    input wire logic config_ind_en,
    // pins
    output logic rx_activity_indicator,
    output logic tx_activity_indicator,
    output logic i2c_activity_indicator,
    output logic suspend_indicator,
    output logic configured_indicator
);
    import fdr_pkg::*;

    // a disabled pin function simply holds its idle level
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            rx_activity_indicator <= 1'b0;
            tx_activity_indicator <= 1'b0;
            i2c_activity_indicator <= 1'b0;
            suspend_indicator <= 1'b0;
            configured_indicator <= 1'b0;
        end
        else
        begin
            rx_activity_indicator <= flags[CS_RX_IDLE_BIT] ^ rx_active;
            tx_activity_indicator <= flags[CS_TX_IDLE_BIT] ^ tx_active;
            i2c_activity_indicator <= flags[CS_I2C_IDLE_BIT]
                ^ (i2c_active & i2c_ind_en);
            suspend_indicator <= flags[CS_SUSPEND_IDLE_BIT]
                ^ (suspended & suspend_ind_en);
            configured_indicator <= flags[CS_CONFIG_IDLE_BIT]
                ^ (usb_configured & config_ind_en);
        end
    end
endmodule
`default_nettype wire

// [rtl/fdr_flash_read_cmd.sv]
// flash data read command handler with avalon register access
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fdr_flash_read_cmd #(
    // arbitrary value, not a real serial number
    parameter logic [127:0] FACTORY_SERIAL = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210,
    parameter logic [7:0] FACTORY_SERIAL_LEN = 8'h10
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // avalon-mm slave
    input wire logic [fdr_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // activity sources
    input wire logic rx_active,
    input wire logic tx_active,
    input wire logic i2c_active,
    input wire logic i2c_ind_en,
    input wire logic suspended,
    input wire logic suspend_ind_en,
    input wire logic usb_configured,
    input wire logic config_ind_en,
    // settings outputs
    output logic serial_enum_en,
    output logic config_locked,
    // indicator pins
    output logic rx_activity_indicator,
    output logic tx_activity_indicator,
    output logic i2c_activity_indicator,
    output logic suspend_indicator,
    output logic configured_indicator
);
    import fdr_pkg::*;

    localparam int FACTORY_BYTES = 16;

    logic [7:0] req_mem [0:REPORT_BYTES-1];
    logic [7:0] rsp_mem [0:REPORT_BYTES-1];
    logic [7:0] flash_mem [0:FLASH_BYTES-1];
    logic [7:0] len_q [0:NUM_STORED_SETS-1];
    fdr_state_t state_q;
    logic [7:0] cmd_q;
    logic [7:0] sub_q;
    logic [5:0] idx_q;
    logic unsup_q;
    logic done_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic go;
    logic bus_wr;
    logic [7:0] cs_flags;

    // byte position in the flat flash image
    function automatic logic [8:0] flat_idx(input logic [2:0] set, input logic [5:0] idx);
        flat_idx = {set, idx};
    endfunction

    // byte position of a bus word lane inside a report-sized window
    function automatic logic [5:0] lane_idx(input logic [7:0] addr, input logic [7:0] base,
                                            input int lane);
        logic [7:0] off;
        off = addr - base;
        lane_idx = {off[3:0], 2'(lane)};
    endfunction

    function automatic logic [7:0] factory_byte(input logic [5:0] idx);
        logic [5:0] k;
        k = idx - RSP_DATA_IDX;
        if (int'(k) < FACTORY_BYTES && idx >= RSP_DATA_IDX)
            factory_byte = FACTORY_SERIAL[8*int'(k) +: 8];
        else
            factory_byte = BYTE_ZERO;
    endfunction

    // one wait cycle per access; the access completes on the following edge
    assign bus_wr = avs_write && !wait_q;
    assign go = bus_wr && (avs_address == A_CTRL) && avs_byteenable[0]
                && avs_writedata[CTRL_GO_BIT];
    assign cs_flags = flash_mem[flat_idx(SUB_CHIP_SETTINGS[2:0], CS_FLAGS_IDX)];

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            wait_q <= 1'b1;
        else if (!wait_q)
            wait_q <= 1'b1;
        else if (avs_read || avs_write)
            wait_q <= 1'b0;
    end

    assign avs_waitrequest = wait_q;

    // read data is captured during the wait cycle so it stands at the completing edge
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            rdata_q <= UNMAPPED_READ;
        else if (avs_read && wait_q)
        begin
            rdata_q <= UNMAPPED_READ;
            if (avs_address >= A_REQ_BASE && avs_address <= A_REQ_END)
            begin
                for (int b = 0; b < WORD_BYTES; b++)
                    rdata_q[8*b +: 8] <= req_mem[lane_idx(avs_address, A_REQ_BASE, b)];
            end
            else if (avs_address >= A_RSP_BASE && avs_address <= A_RSP_END)
            begin
                for (int b = 0; b < WORD_BYTES; b++)
                    rdata_q[8*b +: 8] <= rsp_mem[lane_idx(avs_address, A_RSP_BASE, b)];
            end
            else if (avs_address == A_STATUS)
            begin
                rdata_q[ST_BUSY_BIT] <= (state_q != FDR_IDLE);
                rdata_q[ST_DONE_BIT] <= done_q;
                rdata_q[ST_SERIAL_EN_BIT] <= serial_enum_en;
                rdata_q[ST_LOCKED_BIT] <= config_locked;
                rdata_q[ST_SEC_LSB +: CS_SEC_W] <= cs_flags[CS_SEC_LSB +: CS_SEC_W];
            end
            else if (avs_address >= A_LEN_BASE && avs_address <= A_LEN_END)
                rdata_q[7:0] <= len_q[3'(avs_address - A_LEN_BASE)];
            else if (avs_address >= A_FLASH_BASE && avs_address <= A_FLASH_END)
            begin
                for (int b = 0; b < WORD_BYTES; b++)
                    rdata_q[8*b +: 8] <= flash_mem[9'({avs_address - A_FLASH_BASE, 2'(b)})];
            end
        end
    end

    assign avs_readdata = rdata_q;

    // request report staging
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < REPORT_BYTES; i++)
                req_mem[i] <= BYTE_ZERO;
        end
        else if (bus_wr && avs_address >= A_REQ_BASE && avs_address <= A_REQ_END)
        begin
            for (int b = 0; b < WORD_BYTES; b++)
                if (avs_byteenable[b])
                    req_mem[lane_idx(avs_address, A_REQ_BASE, b)] <= avs_writedata[8*b +: 8];
        end
    end

    // stored data sets; the factory serial is a constant and has no write path
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < FLASH_BYTES; i++)
                flash_mem[i] <= FLASH_RST;
        end
        else if (bus_wr && avs_address >= A_FLASH_BASE && avs_address <= A_FLASH_END)
        begin
            for (int b = 0; b < WORD_BYTES; b++)
                if (avs_byteenable[b])
                    flash_mem[9'({avs_address - A_FLASH_BASE, 2'(b)})]
                        <= avs_writedata[8*b +: 8];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < NUM_STORED_SETS; i++)
                len_q[i] <= LEN_RST;
        end
        else if (bus_wr && avs_address >= A_LEN_BASE && avs_address <= A_LEN_END
                 && avs_byteenable[0])
            len_q[3'(avs_address - A_LEN_BASE)] <= avs_writedata[7:0];
    end

    // command engine: header first, then one data byte per cycle
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            state_q <= FDR_IDLE;
            cmd_q <= BYTE_ZERO;
            sub_q <= BYTE_ZERO;
            idx_q <= RSP_DATA_IDX;
            unsup_q <= 1'b0;
            done_q <= 1'b0;
            for (int i = 0; i < REPORT_BYTES; i++)
                rsp_mem[i] <= BYTE_ZERO;
        end
        else
        begin
            case (state_q)
                FDR_IDLE:
                begin
                    if (go)
                    begin
                        // only the first two request bytes matter
                        cmd_q <= req_mem[REQ_CMD_IDX];
                        sub_q <= req_mem[REQ_SUB_IDX];
                        done_q <= 1'b0;
                        state_q <= FDR_HEAD;
                    end
                end
                FDR_HEAD:
                begin
                    unsup_q <= (cmd_q != CMD_READ_FLASH)
                               || (sub_q > SUB_FACTORY_SERIAL);
                    rsp_mem[RSP_CMD_IDX] <= cmd_q;
                    if (cmd_q != CMD_READ_FLASH || sub_q > SUB_FACTORY_SERIAL)
                    begin
                        rsp_mem[RSP_STS_IDX] <= STS_UNSUPPORTED;
                        rsp_mem[RSP_LEN_IDX] <= BYTE_ZERO;
                    end
                    else
                    begin
                        rsp_mem[RSP_STS_IDX] <= STS_OK;
                        if (sub_q == SUB_FACTORY_SERIAL)
                            rsp_mem[RSP_LEN_IDX] <= FACTORY_SERIAL_LEN;
                        else
                            rsp_mem[RSP_LEN_IDX] <= len_q[sub_q[2:0]];
                    end
                    idx_q <= RSP_DATA_IDX;
                    state_q <= FDR_COPY;
                end
                FDR_COPY:
                begin
                    if (unsup_q)
                        rsp_mem[idx_q] <= BYTE_ZERO;
                    else if (sub_q == SUB_FACTORY_SERIAL)
                        rsp_mem[idx_q] <= factory_byte(idx_q);
                    else
                        rsp_mem[idx_q] <= flash_mem[flat_idx(sub_q[2:0], idx_q)];
                    if (idx_q == RSP_LAST_IDX)
                    begin
                        done_q <= 1'b1;
                        state_q <= FDR_IDLE;
                    end
                    else
                        idx_q <= idx_q + 6'h01;
                end
                default:
                    state_q <= FDR_IDLE;
            endcase
        end
    end

    // live chip settings steer the enumeration and lock outputs
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            serial_enum_en <= 1'b0;
            config_locked <= 1'b0;
        end
        else
        begin
            serial_enum_en <= cs_flags[CS_SERIAL_EN_BIT];
            config_locked <= cs_flags[CS_LOCK_BIT];
        end
    end

    fdr_indicators u_ind (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .flags(cs_flags),
        .rx_active(rx_active),
        .tx_active(tx_active),
        .i2c_active(i2c_active),
        .i2c_ind_en(i2c_ind_en),
        .suspended(suspended),
        .suspend_ind_en(suspend_ind_en),
        .usb_configured(usb_configured),
        .config_ind_en(config_ind_en),
        .rx_activity_indicator(rx_activity_indicator),
        .tx_activity_indicator(tx_activity_indicator),
        .i2c_activity_indicator(i2c_activity_indicator),
        .suspend_indicator(suspend_indicator),
        .configured_indicator(configured_indicator)
    );
endmodule
`default_nettype wire

// [testbench/fdr_flash_read_cmd_monitor.sv]
// port assertions for the flash data read command handler
`timescale 1ns/1ps
`default_nettype none
module fdr_flash_read_cmd_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // bus
    input wire logic [fdr_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // activity
    input wire logic rx_active,
    input wire logic tx_active,
    input wire logic i2c_active,
    input wire logic i2c_ind_en,
    input wire logic suspended,
    input wire logic suspend_ind_en,
    input wire logic usb_configured,
    input wire logic config_ind_en,
    // pins
    input wire logic rx_activity_indicator,
    input wire logic tx_activity_indicator,
    input wire logic i2c_activity_indicator,
    input wire logic suspend_indicator,
    input wire logic configured_indicator
);
    import fdr_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered after one wait cycle");
    AST_WAIT_PULSE: assert property ($fell(avs_waitrequest) |=> $rose(avs_waitrequest))
        else $error("waitrequest low longer than one cycle");
    AST_NO_SPUR: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("answer without a request");
    AST_UNMAP: assert property (avs_read && !avs_waitrequest && (avs_address == 8'hff
        || avs_address == A_CTRL) |-> avs_readdata == UNMAPPED_READ)
        else $error("unmapped or control read not zero");
    AST_RX: assert property ($changed(rx_active) |=> $changed(rx_activity_indicator))
        else $error("rx indicator did not follow receiver");
    AST_TX: assert property (
        $rose(tx_active) |=> tx_activity_indicator != $past(tx_activity_indicator))
        else $error("tx indicator did not follow transmitter");
    AST_I2C_ON: assert property (
        i2c_ind_en && $stable(i2c_ind_en) && $changed(i2c_active)
        |=> $changed(i2c_activity_indicator))
        else $error("i2c indicator did not follow traffic");
    AST_I2C_OFF: assert property (
        !i2c_ind_en && $stable(i2c_ind_en) && $changed(i2c_active)
        |=> $stable(i2c_activity_indicator))
        else $error("disabled i2c indicator moved");
    AST_SUSP: assert property (
        $rose(suspended) && suspend_ind_en && $stable(suspend_ind_en)
        |=> $changed(suspend_indicator))
        else $error("suspend indicator did not follow suspend");
    AST_CFG: assert property (
        $changed(usb_configured) && config_ind_en && $stable(config_ind_en)
        |=> $changed(configured_indicator))
        else $error("configured indicator did not follow configuration");
    cover property (avs_read && !avs_waitrequest);
    cover property ($rose(rx_active));
    cover property (!i2c_ind_en && $changed(i2c_active));
endmodule
bind fdr_flash_read_cmd fdr_flash_read_cmd_monitor u_mon (.core_clk, .rst_b,
    .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
    .rx_active, .tx_active, .i2c_active, .i2c_ind_en, .suspended, .suspend_ind_en,
    .usb_configured, .config_ind_en, .rx_activity_indicator, .tx_activity_indicator,
    .i2c_activity_indicator, .suspend_indicator, .configured_indicator);
`default_nettype wire

// [testbench/fdr_host_model.sv]
// host side model that composes request reports
`timescale 1ns/1ps
`default_nettype none
module fdr_host_model (
    // report fields
    input wire logic [7:0] cmd,
    input wire logic [7:0] sub,
    input wire logic [7:0] junk,
    // composed request report, byte k at bits 8k
    output logic [511:0] req
);
    // junk fills the bytes a polite host zeroes, to show the device ignores them
    always_comb
    begin
        req = {64{junk}};
        req[15:0] = {sub, cmd};
    end
endmodule
`default_nettype wire

// [testbench/fdr_flash_read_cmd_tb_top.sv]
// testbench for the flash data read command handler
`timescale 1ns/1ps
`default_nettype none
module fdr_flash_read_cmd_tb_top;
    import fdr_pkg::*;
    // arbitrary value, not a real serial number
    localparam logic [127:0] FSER = 128'h1f2e_3d4c_5b6a_7988_0011_2233_4455_6677;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic wreq;
    logic [4:0] act = 5'h00;
    logic [2:0] en = 3'h0;
    logic sen;
    logic lck;
    wire logic [4:0] ind;
    logic [7:0] h_cmd = 8'h00;
    logic [7:0] h_sub = 8'h00;
    logic [7:0] h_junk = 8'h00;
    logic [511:0] h_req;
    logic [7:0] flag = 8'h00;
    // chip settings flag bytes and pin activity patterns walked by the main sequence
    logic [7:0] ftab [4] = '{8'he6, 8'h1b, 8'h85, 8'h50};
    logic [4:0] atab [4] = '{5'h00, 5'h1f, 5'h1f, 5'h00};
    logic [2:0] etab [4] = '{3'h7, 3'h7, 3'h0, 3'h0};
    int err_total = 0;
    int n_compared = 0;
    always #2.5 core_clk = ~core_clk;
    fdr_flash_read_cmd #(.FACTORY_SERIAL(FSER)) dut (.core_clk(core_clk), .rst_b(rst_b),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wreq),
        .rx_active(act[4]), .tx_active(act[3]), .i2c_active(act[2]), .i2c_ind_en(en[2]),
        .suspended(act[1]), .suspend_ind_en(en[1]), .usb_configured(act[0]),
        .config_ind_en(en[0]), .serial_enum_en(sen), .config_locked(lck),
        .rx_activity_indicator(ind[4]), .tx_activity_indicator(ind[3]),
        .i2c_activity_indicator(ind[2]), .suspend_indicator(ind[1]),
        .configured_indicator(ind[0]));
    fdr_host_model u_host (.cmd(h_cmd), .sub(h_sub), .junk(h_junk), .req(h_req));
    task automatic results();
        if (err_total == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one bus access; request held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int i;
        @(posedge core_clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        for (i = 0; i < 20; i++)
        begin
            @(posedge core_clk);
            if (wreq === 1'b0)
                break;
        end
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (i == 20)
        begin
            err_total++;
            results();
        end
    endtask
    function automatic logic [31:0] img(input logic [7:0] s, input int w);
        return {s, 8'(w), 8'h5a, (s == 8'h00 && w == 1) ? flag : 8'(w * 3 + 1)};
    endfunction
    function automatic logic [7:0] eb(input logic [7:0] c, s, input int k);
        logic ok;
        logic [31:0] wv;
        ok = (c == CMD_READ_FLASH) && (s <= SUB_FACTORY_SERIAL);
        if (k == 0)
            return c;
        if (k == 1)
            return ok ? STS_OK : STS_UNSUPPORTED;
        if (!ok)
            return 8'h00;
        if (k == 2)
            return (s == SUB_FACTORY_SERIAL) ? 8'h10 : 8'h20 + s;
        if (s == SUB_FACTORY_SERIAL)
            return (k < 19) ? FSER[8 * (k - 3) +: 8] : 8'h00;
        wv = img(s, k / 4);
        return wv[8 * (k % 4) +: 8];
    endfunction
    function automatic logic [31:0] ew(input logic [7:0] c, s, input int w);
        logic [31:0] r;
        for (int b = 0; b < 4; b++)
            r[8 * b +: 8] = eb(c, s, 4 * w + b);
        return r;
    endfunction
    task automatic run(input logic [7:0] c, input logic [7:0] s, input logic [7:0] j);
        logic [31:0] q;
        int i;
        h_cmd = c;
        h_sub = s;
        h_junk = j;
        @(posedge core_clk);
        for (i = 0; i < 16; i++)
            acc(1'b1, A_REQ_BASE + 8'(i), h_req[32 * i +: 32], q);
        acc(1'b1, A_CTRL, 32'h1, q);
        acc(1'b0, A_STATUS, 32'h0, q);
        chk("busy", q[1:0], 2'b01);
        for (i = 0; i < 40; i++)
        begin
            acc(1'b0, A_STATUS, 32'h0, q);
            if (q[0] === 1'b0)
                break;
        end
        if (i == 40)
        begin
            err_total++;
            results();
        end
        chk("done", q[1:0], 2'b10);
        for (i = 0; i < 16; i++)
        begin
            acc(1'b0, A_RSP_BASE + 8'(i), 32'h0, q);
            chk("rsp", q, ew(c, s, i));
        end
    endtask
    initial
    begin
        logic [31:0] q;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        acc(1'b0, A_LEN_BASE, 32'h0, q);
        chk("len reset", q, 32'h0);
        acc(1'b0, A_FLASH_BASE, 32'h0, q);
        chk("image reset", q, 32'h0);
        for (int s = 0; s < 5; s++)
        begin
            acc(1'b1, A_LEN_BASE + 8'(s), 32'h20 + s, q);
            acc(1'b0, A_LEN_BASE + 8'(s), 32'h0, q);
            chk("len", q[7:0], 8'h20 + s);
            for (int w = 0; w < 16; w++)
                acc(1'b1, A_FLASH_BASE + 8'(16 * s + w), img(8'(s), w), q);
        end
        for (int s = 0; s < 8; s++)
            run(CMD_READ_FLASH, 8'(s), 8'hc3);
        run(8'h55, SUB_CHIP_SETTINGS, 8'h00);
        for (int f = 0; f < 4; f++)
        begin
            flag = ftab[f];
            acc(1'b1, A_FLASH_BASE + 8'h01, img(8'h00, 1), q);
            run(CMD_READ_FLASH, SUB_CHIP_SETTINGS, 8'h00);
            chk("serial en", sen, flag[7]);
            chk("locked", lck, flag[1]);
            acc(1'b0, A_STATUS, 32'h0, q);
            chk("status", q[5:2], {flag[1:0], flag[1], flag[7]});
            for (int a = 0; a < 4; a++)
            begin
                act <= atab[a];
                en <= etab[a];
                repeat (3) @(posedge core_clk);
                chk("pins", ind,
                    flag[6:2] ^ (act & {2'b11, en}));
            end
        end
        // response area and unmapped places refuse writes; control reads back zero
        acc(1'b1, A_RSP_BASE, 32'hffff_ffff, q);
        acc(1'b0, A_RSP_BASE, 32'h0, q);
        chk("rsp ro", q, ew(CMD_READ_FLASH, SUB_CHIP_SETTINGS, 0));
        acc(1'b1, 8'hff, 32'hffff_ffff, q);
        acc(1'b0, 8'hff, 32'h0, q);
        chk("unmapped", q, UNMAPPED_READ);
        acc(1'b0, A_CTRL, 32'h0, q);
        chk("ctrl", q, 32'h0);
        run(CMD_READ_FLASH, SUB_FACTORY_SERIAL, 8'h00);
        results();
    end
endmodule
`default_nettype wire
